// File: ursl_peer.sv
// Purpose: remote serial station on the rx and tx lines
// Assumes: divisor 0, so one bit lasts 64 hclk cycles
// Notes: send() can spoil parity or stop; received frames are queued
`timescale 1ns/1ps
`default_nettype none
module ursl_peer
#(
   parameter int BIT_CYC = 64
)
(
   input wire logic hclk,
   input wire logic tx_pin,
   input wire logic [1:0] size,
   input wire logic even,
   input wire logic two,
   output logic rx_pin
);
   // {stop ok, parity bit, data}
   logic [9:0] got_q[$];

   initial rx_pin = 1'b1;

   task automatic bit_out(input logic b);
      rx_pin <= b;
      repeat (BIT_CYC) @(posedge hclk);
   endtask

   // ----------------------------------------------------------------
   // frame towards the receiver
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] d, input logic bad_par,
                       input logic bad_stop);
      logic [7:0] m;
      @(posedge hclk);
      m = d & (8'hff >> (3 - size));
      bit_out(1'b0);
      for (int i = 0; i < 5 + size; i++)
         bit_out(m[i]);
      bit_out((even ? ^m : ~^m) ^ bad_par);
      if (bad_stop)
      begin
         // low past the sampling point only, then back to idle high
         rx_pin <= 1'b0;
         repeat (BIT_CYC * 5 / 8) @(posedge hclk);
         rx_pin <= 1'b1;
         repeat (BIT_CYC * 3 / 8) @(posedge hclk);
      end
      else
         bit_out(1'b1);
      if (two)
         bit_out(1'b1);
   endtask

   // ----------------------------------------------------------------
   // frames from the transmitter, sampled mid-bit
   // ----------------------------------------------------------------
   always
   begin : rx_loop
      logic [7:0] d;
      logic p;
      logic s;
      @(negedge tx_pin);
      repeat (BIT_CYC / 2) @(posedge hclk);
      d = 8'h00;
      for (int i = 0; i < 5 + size; i++)
      begin
         repeat (BIT_CYC) @(posedge hclk);
         d[i] = tx_pin;
      end
      repeat (BIT_CYC) @(posedge hclk);
      p = tx_pin;
      repeat (BIT_CYC) @(posedge hclk);
      s = tx_pin;
      if (two)
      begin
         repeat (BIT_CYC) @(posedge hclk);
         s = s & tx_pin;
      end
      got_q.push_back({s, p, d});
      wait (tx_pin === 1'b1);
   end
endmodule // ursl_peer
`default_nettype wire

// File: ursl_pkg.sv
// Purpose: shared types and the parity helper
// Assumes: frame always carries a parity bit
// Notes: none
`default_nettype none
package ursl_pkg;

   typedef enum logic [4:0]
   {
      FSM_IDLE  = 5'b00001,
      FSM_START = 5'b00010,
      FSM_DATA  = 5'b00100,
      FSM_PAR   = 5'b01000,
      FSM_STOP  = 5'b10000
   } ursl_fsm_type;

   // parity bit for the low 5..8 bits of d
   function automatic logic ursl_par(
      input logic [7:0] d,
      input logic [1:0] sz,
      input logic even
   );
      logic [7:0] m;
      m = d & (8'hff >> (2'd3 - sz));
      return even ? ^m : ~^m;
   endfunction

endpackage
`default_nettype wire

// File: ursl_regs.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 32-bit AHB-Lite words, byte offsets, haddr[11:0] decoded
// Notes: definitions only
`ifndef URSL_REGS_SVH
`define URSL_REGS_SVH

`define URSL_OFF_DATA 12'h160
`define URSL_OFF_STAT 12'h164
`define URSL_OFF_LCRH 12'h168
`define URSL_OFF_BRDM 12'h16c
`define URSL_OFF_BRDL 12'h170
`define URSL_OFF_FLAG 12'h178

`define URSL_LCR_BRK 0
`define URSL_LCR_PEN 1
`define URSL_LCR_EVEN 2
`define URSL_LCR_TWO 3
`define URSL_LCR_FEN 4
`define URSL_LCR_SZ 6:5

`define URSL_ENT_PE 8
`define URSL_ENT_FE 9
`define URSL_FLG_BUSY 3
`define URSL_FLG_RXE 4

`define URSL_LCR_RST 7'h00
`define URSL_BRD_RST 12'h000

`define URSL_HALF 5'd8
`define URSL_MID_TICK 4'h7
`define URSL_END_TICK 4'hf

`endif

// File: ursl_rx.sv
// Purpose: serial receiver, 16x oversampled
// Assumes: rxd already synchronised, tick is one cycle per 1/16 bit
// Notes: configuration is read live
`timescale 1ns/1ps
`default_nettype none
`include "ursl_regs.svh"
module ursl_rx
   import ursl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic rxd,
   input wire logic pen,
   input wire logic even,
   input wire logic two,
   input wire logic [1:0] size,
   output logic vld,
   output logic [7:0] data,
   output logic perr,
   output logic ferr
);

   typedef struct packed {
      ursl_fsm_type st;
      logic [3:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic pb;
      logic fe;
      logic vld;
      logic [7:0] data;
      logic perr;
      logic ferr;
   } ursl_rx_state_type;

   ursl_rx_state_type s_q, s_d;
   logic [7:0] just;

   always_comb
   begin
      s_d = s_q;
      s_d.vld = 1'b0;
      just = s_q.sh >> (2'd3 - size);
      case (s_q.st)
         FSM_IDLE:
            if (!rxd)
            begin
               s_d.st = FSM_START;
               s_d.cnt = 4'h0;
            end
         FSM_START:
            if (tick)
            begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == `URSL_MID_TICK)
               begin
                  s_d.cnt = 4'h0;
                  s_d.bitn = 3'h0;
                  s_d.fe = 1'b0;
                  s_d.st = rxd ? FSM_IDLE : FSM_DATA;
               end
            end
         FSM_DATA:
            if (tick)
            begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == `URSL_END_TICK)
               begin
                  s_d.sh = {rxd, s_q.sh[7:1]};
                  s_d.bitn = s_q.bitn + 3'h1;
                  if (s_q.bitn == {1'b1, size})
                     s_d.st = FSM_PAR;
               end
            end
         FSM_PAR:
            if (tick)
            begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == `URSL_END_TICK)
               begin
                  s_d.pb = rxd;
                  s_d.bitn = 3'h0;
                  s_d.st = FSM_STOP;
               end
            end
         FSM_STOP:
            if (tick)
            begin
               s_d.cnt = s_q.cnt + 4'h1;
               if (s_q.cnt == `URSL_END_TICK)
               begin
                  s_d.fe = s_q.fe | ~rxd;
                  if (two && s_q.bitn == 3'h0)
                     s_d.bitn = 3'h1;
                  else
                  begin
                     s_d.st = FSM_IDLE;
                     s_d.vld = 1'b1;
                     s_d.data = just;
                     s_d.ferr = s_q.fe | ~rxd;
                     s_d.perr = pen &&
                        (s_q.pb != ursl_par(just, size, even));
                  end
               end
            end
         default:
            s_d.st = FSM_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= '{st: FSM_IDLE, default: '0};
      else
         s_q <= s_d;
   end

   assign vld = s_q.vld;
   assign data = s_q.data;
   assign perr = s_q.perr;
   assign ferr = s_q.ferr;

   property p_zero_fill;
      @(posedge hclk) disable iff (!hresetn)
      (s_q.st == FSM_STOP && s_d.vld && size == 2'b00)
         |=> (vld && data[7:5] == 3'b000);
   endproperty
   a_zero_fill: assert property (p_zero_fill)
      else $error("short character not zero filled");

endmodule // ursl_rx
`default_nettype wire

// File: ursl_top.sv
// Purpose: serial port error status, line control and FIFOs on AHB-Lite
// Assumes: one clock; rx_pin is asynchronous
// Notes: zero-wait AHB-Lite slave, always OKAY
//
// What this block does
// - each receive FIFO entry holds framing and parity flags with data
// - parity checking enabled: mismatch against selected type flags error
// - stop bit sampled as zero flags a framing error
// - error status: framing bit 0, parity bit 1, overrun bit 2
// - overrun set on arrival into full FIFO, cleared by data read
// - reception continues unaffected during break
// - parity enable gates only receive check; transmit always adds parity
// - parity mismatch sets bit 8 of the FIFO entry
// - parity type one is even, zero is odd, both directions
// - parity bit follows data as frame MSB; receiver strips it
// - stop select zero: one stop bit sent and expected
// - FIFO enable uses 16 entries, otherwise only one
// - single-entry mode requests service after every frame
// - half full means 8 of 16 entries valid
// - data size 11/10/01/00 selects 8/7/6/5 bits
// - short characters stored right aligned, zero filled
// - line control write commits both divisor parts at once
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ursl_regs.svh"
module ursl_top
   import ursl_pkg::*;
#(
   parameter int DEPTH = 16
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic receive_service_request,
   output logic transmit_service_request
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic rx_m1;
      logic rx_m2;
      logic [13:0] div;
      logic tick;
      logic [DEPTH-1:0][9:0] rxf;
      logic [AW-1:0] rxw;
      logic [AW-1:0] rxr;
      logic [AW:0] rxn;
      logic [DEPTH-1:0][7:0] txf;
      logic [AW-1:0] txw;
      logic [AW-1:0] txr;
      logic [AW:0] txn;
      logic [6:0] lcr;
      logic [11:0] brd;
      logic [3:0] mid_s;
      logic [7:0] low_s;
      logic [1:0] err;
      logic ovr;
      logic wp;
      logic [11:0] wa;
      logic hready;
      logic [31:0] hrdata;
      logic rx_req;
      logic tx_req;
      logic tx_pin;
   } ursl_top_state_type;

   ursl_top_state_type s_q, s_d;

   logic rx_vld, rx_perr, rx_ferr;
   logic [7:0] rx_data;
   logic tx_pop, tx_txd, tx_busy;
   logic acc, rd, rd_data, fen, rx_full, rx_pop, tx_push;
   logic [AW:0] cap;
   logic [31:0] rmux;

   // ------------------------------------------------------------
   // serial engines
   // ------------------------------------------------------------
   ursl_rx u_rx (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(s_q.tick),
      .rxd(s_q.rx_m2),
      .pen(s_q.lcr[`URSL_LCR_PEN]),
      .even(s_q.lcr[`URSL_LCR_EVEN]),
      .two(s_q.lcr[`URSL_LCR_TWO]),
      .size(s_q.lcr[`URSL_LCR_SZ]),
      .vld(rx_vld),
      .data(rx_data),
      .perr(rx_perr),
      .ferr(rx_ferr)
   );

   ursl_tx u_tx (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(s_q.tick),
      .break_control(s_q.lcr[`URSL_LCR_BRK]),
      .even(s_q.lcr[`URSL_LCR_EVEN]),
      .two(s_q.lcr[`URSL_LCR_TWO]),
      .size(s_q.lcr[`URSL_LCR_SZ]),
      .avail(s_q.txn != '0),
      .wdata(s_q.txf[s_q.txr]),
      .pop(tx_pop),
      .txd(tx_txd),
      .busy(tx_busy)
   );

   // ------------------------------------------------------------
   // bus decode and read mux
   // ------------------------------------------------------------
   always_comb
   begin
      acc = hsel && hready && htrans[1];
      rd = acc && !hwrite;
      rd_data = rd && haddr[11:0] == `URSL_OFF_DATA;
      fen = s_q.lcr[`URSL_LCR_FEN];
      cap = fen ? (AW+1)'(DEPTH) : (AW+1)'(1);
      rx_full = s_q.rxn >= cap;
      rx_pop = rd_data && s_q.rxn != '0;
      tx_push = s_q.wp && s_q.wa == `URSL_OFF_DATA && s_q.txn < cap;
      case (haddr[11:0])
         `URSL_OFF_DATA:
            rmux = {24'h0, s_q.rxf[s_q.rxr][7:0]};
         `URSL_OFF_STAT:
            rmux = {29'h0, s_q.ovr, s_q.err};
         `URSL_OFF_LCRH:
            rmux = {25'h0, s_q.lcr};
         `URSL_OFF_BRDM:
            rmux = {28'h0, s_q.mid_s};
         `URSL_OFF_BRDL:
            rmux = {24'h0, s_q.low_s};
         `URSL_OFF_FLAG:
            rmux = {27'h0, s_q.rxn == '0, tx_busy, 3'h0};
         default:
            rmux = 32'h0;
      endcase
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.rx_m1 = rx_pin;
      s_d.rx_m2 = s_q.rx_m1;
      s_d.tick = 1'b0;
      s_d.hready = 1'b1;
      if (s_q.div == 14'h0)
      begin
         s_d.div = {s_q.brd, 2'b11};
         s_d.tick = 1'b1;
      end
      else
         s_d.div = s_q.div - 14'h1;
      s_d.wp = acc && hwrite;
      s_d.wa = haddr[11:0];
      if (rd)
         s_d.hrdata = rmux;
      // receive side runs regardless of break
      if (rx_vld && !rx_full)
      begin
         s_d.rxf[s_q.rxw] = {rx_ferr, rx_perr, rx_data};
         s_d.rxw = s_q.rxw + 1'b1;
      end
      if (rx_pop)
      begin
         s_d.err = {s_q.rxf[s_q.rxr][`URSL_ENT_PE],
            s_q.rxf[s_q.rxr][`URSL_ENT_FE]};
         s_d.rxr = s_q.rxr + 1'b1;
      end
      else if (rd_data)
         s_d.err = 2'b00;
      s_d.rxn = s_q.rxn + (AW+1)'(rx_vld && !rx_full) - (AW+1)'(rx_pop);
      if (rd_data)
         s_d.ovr = 1'b0;
      if (rx_vld && rx_full)
         s_d.ovr = 1'b1;
      if (tx_push)
      begin
         s_d.txf[s_q.txw] = hwdata[7:0];
         s_d.txw = s_q.txw + 1'b1;
      end
      if (tx_pop)
         s_d.txr = s_q.txr + 1'b1;
      s_d.txn = s_q.txn + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      if (s_q.wp)
      begin
         case (s_q.wa)
            `URSL_OFF_LCRH:
            begin
               s_d.lcr = hwdata[6:0];
               s_d.brd = {s_q.mid_s, s_q.low_s};
            end
            `URSL_OFF_BRDM:
               s_d.mid_s = hwdata[3:0];
            `URSL_OFF_BRDL:
               s_d.low_s = hwdata[7:0];
            default:
               s_d.lcr = s_q.lcr;
         endcase
      end
      if (fen)
      begin
         s_d.rx_req = s_d.rxn >= `URSL_HALF;
         s_d.tx_req = s_d.txn < `URSL_HALF;
      end
      else
      begin
         s_d.rx_req = s_d.rxn != '0;
         s_d.tx_req = s_d.txn == '0;
      end
      s_d.tx_pin = tx_txd;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= '{lcr: `URSL_LCR_RST, brd: `URSL_BRD_RST, hready: 1'b1,
            tx_pin: 1'b1, rx_m1: 1'b1, rx_m2: 1'b1, default: '0};
      else
         s_q <= s_d;
   end

   assign hreadyout = s_q.hready;
   assign hresp = 1'b0;
   assign hrdata = s_q.hrdata;
   assign tx_pin = s_q.tx_pin;
   assign receive_service_request = s_q.rx_req;
   assign transmit_service_request = s_q.tx_req;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_brk_idle;
      (s_q.lcr[`URSL_LCR_BRK] && !tx_busy)[*3];
   endsequence

   property p_stat_read;
      (rd && haddr[11:0] == `URSL_OFF_STAT)
         |=> (hrdata[31:3] == 29'h0 && hrdata[2] == $past(s_q.ovr));
   endproperty
   a_stat_read: assert property (p_stat_read)
      else $error("status read wrong");

   property p_ovr_set;
      (rx_vld && rx_full) |=> s_q.ovr;
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("overrun not set");

   property p_ovr_clr;
      (rd_data && !(rx_vld && rx_full)) |=> !s_q.ovr;
   endproperty
   a_ovr_clr: assert property (p_ovr_clr)
      else $error("overrun not cleared by data read");

   property p_commit;
      (s_q.wp && s_q.wa == `URSL_OFF_LCRH)
         |=> (s_q.brd[11:8] == $past(s_q.mid_s)
            && s_q.brd[7:0] == $past(s_q.low_s));
   endproperty
   a_commit: assert property (p_commit)
      else $error("divisor not committed");

   property p_brk_low;
      s_brk_idle |-> !tx_pin;
   endproperty
   a_brk_low: assert property (p_brk_low)
      else $error("break not driving line low");

   property p_brk_nofetch;
      (s_q.lcr[`URSL_LCR_BRK] && !tx_busy) |=> !tx_pop;
   endproperty
   a_brk_nofetch: assert property (p_brk_nofetch)
      else $error("fetch during break");

   property p_half;
      ($past(fen) && s_q.rxn >= `URSL_HALF) |-> receive_service_request;
   endproperty
   a_half: assert property (p_half)
      else $error("half full request missing");

   property p_single;
      (!fen && s_q.rxn != '0 && !rx_pop) |=> receive_service_request;
   endproperty
   a_single: assert property (p_single)
      else $error("single entry request missing");

   property p_cap;
      (!fen && !$past(fen)) |-> s_q.rxn <= (AW+1)'(1);
   endproperty
   a_cap: assert property (p_cap)
      else $error("single entry mode over filled");

endmodule // ursl_top
`default_nettype wire

// File: ursl_top_bench.sv
// Purpose: self-checking bench for the serial port status and control
// Assumes: zero-wait slave, divisor 0 (64 cycles per bit)
// Notes: expected values are worked out here from the line settings
`timescale 1ns/1ps
`default_nettype none
`include "ursl_regs.svh"
module ursl_top_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, rx_pin, tx_pin, rx_req, tx_req;
   logic [31:0] hrdata;
   logic [1:0] size = 2'h0;
   logic even = 1'b0;
   logic two = 1'b0;
   int n_mismatch = 0;
   int tests_run = 0;

   always #2.5 hclk = ~hclk;

   ursl_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .receive_service_request(rx_req),
      .transmit_service_request(tx_req));

   ursl_peer u_peer (.hclk(hclk), .tx_pin(tx_pin), .size(size),
      .even(even), .two(two), .rx_pin(rx_pin));

   // ----------------------------------------------------------------
   // bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_ready();
      do
         @(posedge hclk);
      while (hreadyout !== 1'b1);
   endtask

   task automatic bus(input logic wr, input logic [11:0] off,
                      input logic [31:0] wd, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {20'h0, off};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      q = hrdata;
      check("response", {31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [11:0] off, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, off, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [11:0] off,
                         input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, off, 32'h0, q);
      check(what, q, exp);
   endtask

   task automatic set_lcr(input logic [6:0] v);
      wr(`URSL_OFF_BRDL, 32'h0);
      wr(`URSL_OFF_BRDM, 32'h0);
      wr(`URSL_OFF_LCRH, {25'h0, v});
      size <= v[6:5];
      even <= v[2];
      two <= v[3];
   endtask

   task automatic wait_q(input int n);
      for (int i = 0; i < 1000 * n && u_peer.got_q.size() < n; i++)
         @(posedge hclk);
      if (u_peer.got_q.size() < n)
         n_mismatch++;
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      logic [7:0] m;
      logic [9:0] f;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk("status", `URSL_OFF_STAT, 32'h0);
      rd_chk("control", `URSL_OFF_LCRH, 32'h0);
      rd_chk("flags", `URSL_OFF_FLAG, 32'h10);
      rd_chk("unmapped", 12'h17c, 32'h0);
      check("tx request", {31'h0, tx_req}, 32'h1);
      $display("test reset done");
      for (int s = 0; s < 4; s++)
      begin
         set_lcr({s[1:0], 1'b0, s[1], s[0], 1'b1, 1'b0});
         m = 8'hff >> (3 - s);
         u_peer.send(8'hff, 1'b0, 1'b0);
         rd_chk("rx data", `URSL_OFF_DATA, {24'h0, m});
         rd_chk("rx status", `URSL_OFF_STAT, 32'h0);
         u_peer.got_q.delete();
         wr(`URSL_OFF_DATA, 32'hd6);
         wait_q(1);
         f = u_peer.got_q[0];
         check("tx data", {24'h0, f[7:0]}, {24'h0, 8'hd6 & m});
         check("tx parity", {31'h0, f[8]},
            {31'h0, s[0] ? ^(8'hd6 & m) : ~^(8'hd6 & m)});
         check("tx stop", {31'h0, f[9]}, 32'h1);
         repeat (128) @(posedge hclk);
      end
      $display("test sizes done");
      set_lcr(7'h66);
      u_peer.send(8'h5a, 1'b1, 1'b0);
      rd_chk("parity data", `URSL_OFF_DATA, 32'h5a);
      rd_chk("parity status", `URSL_OFF_STAT, 32'h2);
      u_peer.send(8'h33, 1'b0, 1'b1);
      rd_chk("stop data", `URSL_OFF_DATA, 32'h33);
      rd_chk("stop status", `URSL_OFF_STAT, 32'h1);
      set_lcr(7'h64);
      u_peer.send(8'h5a, 1'b1, 1'b0);
      rd_chk("unchecked data", `URSL_OFF_DATA, 32'h5a);
      rd_chk("unchecked status", `URSL_OFF_STAT, 32'h0);
      $display("test errors done");
      set_lcr(7'h60);
      u_peer.send(8'h11, 1'b0, 1'b0);
      check("rx request", {31'h0, rx_req}, 32'h1);
      u_peer.send(8'h22, 1'b0, 1'b0);
      rd_chk("overrun status", `URSL_OFF_STAT, 32'h4);
      rd_chk("kept data", `URSL_OFF_DATA, 32'h11);
      rd_chk("overrun clear", `URSL_OFF_STAT, 32'h0);
      rd_chk("second dropped", `URSL_OFF_FLAG, 32'h10);
      check("rx request off", {31'h0, rx_req}, 32'h0);
      $display("test overrun done");
      set_lcr(7'h70);
      for (int i = 0; i < 8; i++)
      begin
         check("rx below half", {31'h0, rx_req}, 32'h0);
         u_peer.send(8'h40 + i[7:0], 1'b0, 1'b0);
      end
      repeat (4) @(posedge hclk);
      check("rx at half", {31'h0, rx_req}, 32'h1);
      for (int i = 0; i < 8; i++)
         rd_chk("rx fifo", `URSL_OFF_DATA, 32'h40 + i);
      u_peer.got_q.delete();
      for (int i = 0; i < 10; i++)
         wr(`URSL_OFF_DATA, 32'h80 + i);
      repeat (2) @(posedge hclk);
      check("tx above half", {31'h0, tx_req}, 32'h0);
      wait_q(10);
      for (int i = 0; i < 10; i++)
      begin
         f = u_peer.got_q[i];
         check("tx fifo", {24'h0, f[7:0]}, 32'h80 + i);
      end
      check("tx drained", {31'h0, tx_req}, 32'h1);
      $display("test fifo done");
      set_lcr(7'h60);
      u_peer.got_q.delete();
      wr(`URSL_OFF_DATA, 32'hc3);
      repeat (200) @(posedge hclk);
      wr(`URSL_OFF_LCRH, 32'h61);
      wr(`URSL_OFF_DATA, 32'hff);
      u_peer.send(8'h5a, 1'b0, 1'b0);
      rd_chk("break rx data", `URSL_OFF_DATA, 32'h5a);
      rd_chk("break rx status", `URSL_OFF_STAT, 32'h0);
      f = u_peer.got_q[0];
      check("frame finished", {22'h0, f}, 32'h3c3);
      for (int i = 0; i < 16; i++)
      begin
         repeat (64) @(posedge hclk);
         check("break level", {31'h0, tx_pin}, 32'h0);
      end
      wr(`URSL_OFF_LCRH, 32'h60);
      wait_q(3);
      f = u_peer.got_q[u_peer.got_q.size() - 1];
      check("after break", {22'h0, f}, 32'h3ff);
      $display("test break done");
      stop_test();
   end

   initial
   begin
      repeat (60000) @(posedge hclk);
      n_mismatch++;
      stop_test();
   end
endmodule // ursl_top_bench
`default_nettype wire

// File: ursl_tx.sv
// Purpose: serial transmitter with break and parity generation
// Assumes: tick is one cycle per 1/16 bit
// Notes: a frame starts only on a tick
`timescale 1ns/1ps
`default_nettype none
`include "ursl_regs.svh"
module ursl_tx
   import ursl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tick,
   input wire logic break_control,
   input wire logic even,
   input wire logic two,
   input wire logic [1:0] size,
   input wire logic avail,
   input wire logic [7:0] wdata,
   output logic pop,
   output logic txd,
   output logic busy
);

   typedef struct packed {
      ursl_fsm_type st;
      logic [3:0] cnt;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic pb;
      logic txd;
      logic pop;
   } ursl_tx_state_type;

   ursl_tx_state_type s_q, s_d;
   logic bit_end;

   always_comb
   begin
      s_d = s_q;
      s_d.pop = 1'b0;
      bit_end = tick && s_q.cnt == `URSL_END_TICK;
      if (tick)
         s_d.cnt = s_q.cnt + 4'h1;
      case (s_q.st)
         FSM_IDLE:
         begin
            s_d.txd = ~break_control;
            // start only from a high line, so a break ends in a visible edge
            if (!break_control && avail && tick && s_q.txd)
            begin
               s_d.pop = 1'b1;
               s_d.sh = wdata;
               s_d.pb = ursl_par(wdata, size, even);
               s_d.st = FSM_START;
               s_d.txd = 1'b0;
               s_d.cnt = 4'h0;
            end
         end
         FSM_START:
            if (bit_end)
            begin
               s_d.st = FSM_DATA;
               s_d.txd = s_q.sh[0];
               s_d.sh = {1'b0, s_q.sh[7:1]};
               s_d.bitn = 3'h0;
            end
         FSM_DATA:
            if (bit_end)
            begin
               if (s_q.bitn == {1'b1, size})
               begin
                  s_d.st = FSM_PAR;
                  s_d.txd = s_q.pb;
               end
               else
               begin
                  s_d.txd = s_q.sh[0];
                  s_d.sh = {1'b0, s_q.sh[7:1]};
                  s_d.bitn = s_q.bitn + 3'h1;
               end
            end
         FSM_PAR:
            if (bit_end)
            begin
               s_d.st = FSM_STOP;
               s_d.txd = 1'b1;
               s_d.bitn = 3'h0;
            end
         FSM_STOP:
            if (bit_end)
            begin
               if (two && s_q.bitn == 3'h0)
                  s_d.bitn = 3'h1;
               else
                  s_d.st = FSM_IDLE;
            end
         default:
            s_d.st = FSM_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_q <= '{st: FSM_IDLE, txd: 1'b1, default: '0};
      else
         s_q <= s_d;
   end

   assign pop = s_q.pop;
   assign txd = s_q.txd;
   assign busy = s_q.st != FSM_IDLE;

endmodule // ursl_tx
`default_nettype wire
